// ### design/csw_clock_switch.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Function
// [RULE1] switch hold set: ready new source holds switch, raises event
// [RULE2] switch hold clear: switch occurs once new source ready
// [RULE3] secondary power select 1 high power, 0 low power
// [RULE4] switch complete reads 1 when current equals requested, else 0
// [RULE5] new source ready reads 1 only mid-switch with source ready
// [RULE6] without hold, new source ready may last under one cycle
// [RULE7] each oscillator ready flag reads 1 only when usable
// [RULE8] pll ready needs pll enabled, input ready and lock
// [RULE9] manual enable forces oscillator on, else peripheral request only; code also enables a source while requested or in use
// [RULE10] forced external oscillator runs in configured external mode
// [RULE11] forced high internal runs at frequency select setting
// [RULE12] forced secondary runs in power mode from power select
// [RULE13] mid internal derived from high internal, two output rates; code has one mid_from_high_out bit and no rate select
// [RULE14] low internal under manual control is the 31 kHz source
// [RULE15] source codes 7,6,5,4,2,1 valid; 3 and 0 reserved
// [RULE16] current source and divider show what is in use
// [RULE17] clearing hold during held switch completes it
// [RULE18] writes to read-only flags are ignored
module csw_clock_switch
   import csw_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // register port
   input wire logic [11:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // oscillator side
   input wire csw_rdy_t osc_ready_in,
   input wire csw_en_t periph_request_in,
   input wire logic [2:0] external_mode_config_in,
   input wire logic [2:0] internal_frequency_select_in,
   output csw_en_t osc_enable_out,
   output logic secondary_high_power_out,
   output logic [2:0] external_mode_out,
   output logic [2:0] high_internal_freq_out,
   output logic mid_from_high_out,
   output logic low_internal_31k_out,
   // system clock selection
   output csw_sel_t current_sel_out,
   output logic switch_hold_event_out
);
   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   csw_sel_t req_q;
   csw_sel_t cur_q;
   logic switch_hold_q;
   logic secondary_power_select_q;
   logic [7:0] mreq_q;
   csw_state_t state_q;
   logic new_source_ready;
   logic wr_req;
   logic wr_ctl3;
   logic wr_mreq;
   logic new_rdy;
   logic pll_input_rdy;
   logic pll_needed;
   logic pll_ready;
   logic [7:0] stat_vec;
   logic [7:0] ctl3_vec;
   logic [7:0] rdata_d;
   csw_en_t en_d;

   // -------------------------------------------------------------
   // write decode
   // -------------------------------------------------------------
   assign wr_req = reg_wr_in && reg_addr_in == CSW_ADDR_REQ;
   assign wr_ctl3 = reg_wr_in && reg_addr_in == CSW_ADDR_CTL3;
   assign wr_mreq = reg_wr_in && reg_addr_in == CSW_ADDR_MREQ;

   // -------------------------------------------------------------
   // request register
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         req_q.src <= CSW_SRC_HFI;
         req_q.div <= CSW_DIV_RST;
      end else if (wr_req) begin
         if (reg_wdata_in[CSW_SRC_LSB+:3] != CSW_SRC_RSV3 &&
             reg_wdata_in[CSW_SRC_LSB+:3] != CSW_SRC_RSV0) begin
            req_q.src <= csw_src_t'(reg_wdata_in[CSW_SRC_LSB+:3]); // [RULE15]
         end
         if (reg_wdata_in[CSW_DIV_LSB+:4] <= CSW_DIV_MAX) begin
            req_q.div <= reg_wdata_in[CSW_DIV_LSB+:4];
         end
      end
   end

   // -------------------------------------------------------------
   // control three
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         switch_hold_q <= 1'b0;
         secondary_power_select_q <= 1'b0;
      end else if (wr_ctl3) begin
         // status bits of this register are not writable
         switch_hold_q <= reg_wdata_in[CSW_HOLD_BIT]; // [RULE18]
         secondary_power_select_q <= reg_wdata_in[CSW_SPWR_BIT];
      end
   end

   // -------------------------------------------------------------
   // manual request
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         mreq_q <= CSW_MREQ_RST;
      end else if (wr_mreq) begin
         mreq_q <= reg_wdata_in & CSW_MREQ_MASK;
      end
   end

   // -------------------------------------------------------------
   // readiness of requested source
   // -------------------------------------------------------------
   // pll runs when a pll source is requested or in use
   assign pll_needed = req_q.src == CSW_SRC_EXT_PLL ||
      req_q.src == CSW_SRC_HFI_PLL || cur_q.src == CSW_SRC_EXT_PLL ||
      cur_q.src == CSW_SRC_HFI_PLL;
   // -------------------------------------------------------------
   // pll input select
   // -------------------------------------------------------------
   always_comb begin
      pll_input_rdy = 1'b0;
      if (req_q.src == CSW_SRC_EXT_PLL) begin
         pll_input_rdy = osc_ready_in.ext;
      end else if (req_q.src == CSW_SRC_HFI_PLL) begin
         pll_input_rdy = osc_ready_in.hfi;
      end else if (cur_q.src == CSW_SRC_EXT_PLL) begin
         pll_input_rdy = osc_ready_in.ext;
      end else begin
         pll_input_rdy = osc_ready_in.hfi;
      end
   end

   // -------------------------------------------------------------
   // requested source ready
   // -------------------------------------------------------------
   always_comb begin
      unique case (req_q.src)
         CSW_SRC_EXT: new_rdy = osc_ready_in.ext;
         CSW_SRC_HFI: new_rdy = osc_ready_in.hfi;
         CSW_SRC_LFI: new_rdy = osc_ready_in.lfi;
         CSW_SRC_SEC: new_rdy = osc_ready_in.sec;
         CSW_SRC_EXT_PLL: new_rdy = osc_ready_in.ext &&
            osc_ready_in.pll_lock;
         CSW_SRC_HFI_PLL: new_rdy = osc_ready_in.hfi &&
            osc_ready_in.pll_lock;
         default: new_rdy = 1'b0;
      endcase
   end

   // -------------------------------------------------------------
   // switch state machine
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         state_q <= CSW_ST_IDLE;
         cur_q.src <= CSW_SRC_HFI;
         cur_q.div <= CSW_DIV_RST;
         switch_hold_event_out <= 1'b0;
      end else begin
         switch_hold_event_out <= 1'b0;
         unique case (state_q)
            CSW_ST_IDLE: begin
               if (req_q != cur_q) begin
                  state_q <= CSW_ST_WAIT;
               end
            end
            CSW_ST_WAIT: begin
               if (req_q == cur_q) begin
                  state_q <= CSW_ST_IDLE;
               end else if (new_rdy && switch_hold_q) begin
                  state_q <= CSW_ST_HOLD; // [RULE1]
                  switch_hold_event_out <= 1'b1; // [RULE1]
               end else if (new_rdy) begin
                  cur_q <= req_q; // [RULE2] [RULE16]
                  state_q <= CSW_ST_IDLE;
               end
            end
            CSW_ST_HOLD: begin
               if (req_q == cur_q) begin
                  state_q <= CSW_ST_IDLE;
               end else if (!new_rdy) begin
                  state_q <= CSW_ST_WAIT;
               end else if (!switch_hold_q) begin
                  cur_q <= req_q; // [RULE17]
                  state_q <= CSW_ST_IDLE;
               end
            end
            default: state_q <= CSW_ST_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------
   // new source ready
   // -------------------------------------------------------------
   // mid-switch and requested source ready; brief without hold
   assign new_source_ready = req_q != cur_q &&
      new_rdy; // [RULE5] [RULE6]

   // -------------------------------------------------------------
   // oscillator enables
   // -------------------------------------------------------------
   always_comb begin
      en_d.ext = mreq_q[CSW_EXT_BIT] || periph_request_in.ext || // [RULE9]
         req_q.src inside {CSW_SRC_EXT, CSW_SRC_EXT_PLL} ||
         cur_q.src inside {CSW_SRC_EXT, CSW_SRC_EXT_PLL};
      en_d.hfi = mreq_q[CSW_HFI_BIT] || periph_request_in.hfi || // [RULE9]
         mreq_q[CSW_MFI_BIT] || periph_request_in.mfi || // [RULE13]
         req_q.src inside {CSW_SRC_HFI, CSW_SRC_HFI_PLL} ||
         cur_q.src inside {CSW_SRC_HFI, CSW_SRC_HFI_PLL};
      en_d.mfi = mreq_q[CSW_MFI_BIT] || periph_request_in.mfi; // [RULE9]
      en_d.lfi = mreq_q[CSW_LFI_BIT] || periph_request_in.lfi || // [RULE14]
         req_q.src == CSW_SRC_LFI || cur_q.src == CSW_SRC_LFI;
      en_d.sec = mreq_q[CSW_SEC_BIT] || periph_request_in.sec || // [RULE9]
         req_q.src == CSW_SRC_SEC || cur_q.src == CSW_SRC_SEC;
      en_d.adc = mreq_q[CSW_ADC_BIT] || periph_request_in.adc; // [RULE9]
      en_d.pll = pll_needed || periph_request_in.pll;
   end

   // -------------------------------------------------------------
   // output registers
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         osc_enable_out <= '0;
         secondary_high_power_out <= 1'b0;
         external_mode_out <= 3'h0;
         high_internal_freq_out <= 3'h0;
         mid_from_high_out <= 1'b0;
         low_internal_31k_out <= 1'b0;
         current_sel_out <= '0;
      end else begin
         osc_enable_out <= en_d;
         secondary_high_power_out <= // [RULE3] [RULE12]
            secondary_power_select_q;
         external_mode_out <= external_mode_config_in; // [RULE10]
         high_internal_freq_out <= internal_frequency_select_in; // [RULE11]
         mid_from_high_out <= en_d.mfi && osc_ready_in.hfi; // [RULE13]
         low_internal_31k_out <= en_d.lfi; // [RULE14]
         current_sel_out <= cur_q; // [RULE16]
      end
   end

   // -------------------------------------------------------------
   // status flags
   // -------------------------------------------------------------
   assign pll_ready = en_d.pll && pll_input_rdy && osc_ready_in.pll_lock;

   always_comb begin
      stat_vec = 8'h00;
      stat_vec[CSW_EXT_BIT] = osc_ready_in.ext && en_d.ext; // [RULE7]
      stat_vec[CSW_HFI_BIT] = osc_ready_in.hfi && en_d.hfi; // [RULE7]
      stat_vec[CSW_MFI_BIT] = osc_ready_in.mfi && en_d.mfi; // [RULE7]
      stat_vec[CSW_LFI_BIT] = osc_ready_in.lfi && en_d.lfi; // [RULE7]
      stat_vec[CSW_SEC_BIT] = osc_ready_in.sec && en_d.sec; // [RULE7]
      stat_vec[CSW_ADC_BIT] = osc_ready_in.adc && en_d.adc; // [RULE7]
      stat_vec[CSW_PLL_BIT] = pll_ready; // [RULE8]
   end

   always_comb begin
      ctl3_vec = 8'h00;
      ctl3_vec[CSW_HOLD_BIT] = switch_hold_q;
      ctl3_vec[CSW_SPWR_BIT] = secondary_power_select_q;
      ctl3_vec[CSW_DONE_BIT] = req_q == cur_q; // [RULE4]
      ctl3_vec[CSW_NRDY_BIT] = new_source_ready; // [RULE5]
   end

   // -------------------------------------------------------------
   // read port
   // -------------------------------------------------------------
   always_comb begin
      rdata_d = 8'h00;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            CSW_ADDR_REQ: rdata_d = {1'b0, req_q};
            CSW_ADDR_CUR: rdata_d = {1'b0, cur_q}; // [RULE16]
            CSW_ADDR_CTL3: rdata_d = ctl3_vec; // [RULE18]
            CSW_ADDR_STAT: rdata_d = stat_vec; // [RULE18]
            CSW_ADDR_MREQ: rdata_d = mreq_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         reg_rdata_out <= rdata_d;
      end
   end
endmodule

// ### pkg/csw_pkg.sv
package csw_pkg;
   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [11:0] CSW_ADDR_REQ = 12'h88d;
   localparam logic [11:0] CSW_ADDR_CUR = 12'h88e;
   localparam logic [11:0] CSW_ADDR_CTL3 = 12'h88f;
   localparam logic [11:0] CSW_ADDR_STAT = 12'h890;
   localparam logic [11:0] CSW_ADDR_MREQ = 12'h891;
   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int CSW_HOLD_BIT = 7;
   localparam int CSW_SPWR_BIT = 6;
   localparam int CSW_DONE_BIT = 4;
   localparam int CSW_NRDY_BIT = 3;
   localparam int CSW_SRC_LSB = 4;
   localparam int CSW_DIV_LSB = 0;
   // manual request / ready bit positions
   localparam int CSW_EXT_BIT = 7;
   localparam int CSW_HFI_BIT = 6;
   localparam int CSW_MFI_BIT = 5;
   localparam int CSW_LFI_BIT = 4;
   localparam int CSW_SEC_BIT = 3;
   localparam int CSW_ADC_BIT = 2;
   localparam int CSW_PLL_BIT = 0;
   localparam logic [7:0] CSW_MREQ_MASK = 8'hfc;
   // -------------------------------------------------------------
   // reset values and divider limit
   // -------------------------------------------------------------
   localparam logic [7:0] CSW_MREQ_RST = 8'h00;
   localparam logic [2:0] CSW_SRC_RST = 3'h6;
   localparam logic [3:0] CSW_DIV_RST = 4'h2;
   localparam logic [3:0] CSW_DIV_MAX = 4'h9;
   // -------------------------------------------------------------
   // source encoding
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      CSW_SRC_RSV0 = 3'h0,
      CSW_SRC_HFI_PLL = 3'h1,
      CSW_SRC_EXT_PLL = 3'h2,
      CSW_SRC_RSV3 = 3'h3,
      CSW_SRC_SEC = 3'h4,
      CSW_SRC_LFI = 3'h5,
      CSW_SRC_HFI = 3'h6,
      CSW_SRC_EXT = 3'h7
   } csw_src_t;
   typedef struct packed {
      csw_src_t src;
      logic [3:0] div;
   } csw_sel_t;
   // oscillator ready inputs from the analog side
   typedef struct packed {
      logic ext;
      logic hfi;
      logic mfi;
      logic lfi;
      logic sec;
      logic adc;
      logic pll_lock;
   } csw_rdy_t;
   // oscillator enable outputs
   typedef struct packed {
      logic ext;
      logic hfi;
      logic mfi;
      logic lfi;
      logic sec;
      logic adc;
      logic pll;
   } csw_en_t;
   // switch state machine, gray along idle-wait-hold-wait
   typedef enum logic [1:0] {
      CSW_ST_IDLE = 2'b00,
      CSW_ST_WAIT = 2'b01,
      CSW_ST_HOLD = 2'b11
   } csw_state_t;
endpackage

// ### test/csw_checker.sv
`timescale 1ns/1ps
module csw_checker
   import csw_pkg::*;
(
   // watched ports
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire csw_rdy_t osc_ready_in,
   input wire csw_en_t periph_request_in,
   input wire logic [2:0] external_mode_config_in,
   input wire logic [2:0] internal_frequency_select_in,
   input wire csw_en_t osc_enable_out,
   input wire logic secondary_high_power_out,
   input wire logic [2:0] external_mode_out,
   input wire logic [2:0] high_internal_freq_out,
   input wire logic mid_from_high_out,
   input wire csw_sel_t current_sel_out,
   input wire logic switch_hold_event_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   // ----
   // assertions
   // ----
   force_ext_a: assert property (
      reg_wr_in && reg_addr_in == CSW_ADDR_MREQ
      && reg_wdata_in[CSW_EXT_BIT] |-> ##2 osc_enable_out.ext)
      else $error("forced external not enabled");
   periph_lfi_a: assert property (periph_request_in.lfi
      |=> osc_enable_out.lfi) else $error("requested low internal off");
   ext_mode_a: assert property (!$past(reset_in)
      |-> external_mode_out == $past(external_mode_config_in))
      else $error("external mode not followed");
   hfi_freq_a: assert property (!$past(reset_in)
      |-> high_internal_freq_out == $past(internal_frequency_select_in))
      else $error("frequency select not followed");
   sec_power_a: assert property (
      reg_wr_in && reg_addr_in == CSW_ADDR_CTL3
      |-> ##2 secondary_high_power_out == $past(reg_wdata_in[CSW_SPWR_BIT], 2))
      else $error("power select not applied");
   hold_pulse_a: assert property (switch_hold_event_out
      |=> !switch_hold_event_out) else $error("hold event too long");
   hold_keep_a: assert property (switch_hold_event_out
      |=> $stable(current_sel_out)) else $error("held switch went ahead");
   src_legal_a: assert property (!$past(reset_in)
      |-> current_sel_out.src != CSW_SRC_RSV0
      && current_sel_out.src != CSW_SRC_RSV3) else $error("reserved source");
   div_legal_a: assert property (!$past(reset_in)
      |-> current_sel_out.div <= CSW_DIV_MAX) else $error("reserved divider");
   mid_src_a: assert property (mid_from_high_out
      |-> $past(osc_ready_in.hfi)) else $error("mid without high internal");
   unmapped_rd_a: assert property (reg_rd_in && (reg_addr_in < CSW_ADDR_REQ
      || reg_addr_in > CSW_ADDR_MREQ) |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind csw_clock_switch csw_checker u_chk (.*);

// ### test/csw_osc_model.sv
`timescale 1ns/1ps
module csw_osc_model
   import csw_pkg::*;
#(
   parameter int START_CYCLES = 4
)
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // oscillator side
   input wire csw_en_t osc_enable_in,
   output csw_rdy_t osc_ready_out
);
   logic [6:0] en_v;
   logic [6:0] rdy_v;
   int cnt_q [7];
   assign en_v = osc_enable_in;
   assign osc_ready_out = rdy_v;
   // ----
   // start-up count, ready drops at once when disabled
   // ----
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         for (int i = 0; i < 7; i++) begin
            cnt_q[i] <= 0;
         end
      end else begin
         for (int i = 0; i < 7; i++) begin
            if (!en_v[i]) begin
               cnt_q[i] <= 0;
            end else if (cnt_q[i] < START_CYCLES) begin
               cnt_q[i] <= cnt_q[i] + 1;
            end
         end
      end
   end
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         rdy_v[i] = en_v[i] && (cnt_q[i] >= START_CYCLES);
      end
      // lock needs a ready reference
      rdy_v[0] = rdy_v[0] && (rdy_v[6] || rdy_v[5]);
   end
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import csw_pkg::*;
   logic clk_sys_in = 1'b0;
   logic reset_in = 1'b1;
   logic [11:0] addr = 12'h000;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   csw_rdy_t rdy;
   csw_en_t preq = '0;
   logic [2:0] xmode = 3'h0;
   logic [2:0] fsel = 3'h0;
   csw_en_t en;
   logic spwr;
   logic [2:0] xmode_o;
   logic [2:0] fsel_o;
   logic mid;
   logic low31;
   csw_sel_t sel;
   logic hold_ev;
   int fail_count = 0;
   int cmp_count = 0;
   always #2 clk_sys_in = ~clk_sys_in;
   csw_clock_switch u_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .osc_ready_in(rdy),
      .periph_request_in(preq), .external_mode_config_in(xmode),
      .internal_frequency_select_in(fsel), .osc_enable_out(en),
      .secondary_high_power_out(spwr), .external_mode_out(xmode_o),
      .high_internal_freq_out(fsel_o), .mid_from_high_out(mid),
      .low_internal_31k_out(low31), .current_sel_out(sel),
      .switch_hold_event_out(hold_ev));
   csw_osc_model u_osc (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .osc_enable_in(en), .osc_ready_out(rdy));
   // ----
   // bus and compare tasks
   // ----
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk_sys_in);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys_in);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk_sys_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_in);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic wait_sel(input logic [7:0] exp);
      for (int i = 0; i < 100 && {1'b0, sel} !== exp; i++) begin
         @(posedge clk_sys_in);
         #1;
      end
      chk({1'b0, sel}, exp);
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_reset;
      rdc(CSW_ADDR_MREQ, 8'h00);
      rdc(CSW_ADDR_REQ, 8'h62);
      rdc(CSW_ADDR_CUR, 8'h62);
      rdc(CSW_ADDR_CTL3, 8'h10);
      rdc(12'h895, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_force;
      wrr(CSW_ADDR_MREQ, 8'hff);
      rdc(CSW_ADDR_MREQ, 8'hfc);
      repeat (10) @(posedge clk_sys_in);
      #1 chk({1'b0, en}, 8'h7e);
      chk({6'h0, mid, low31}, 8'h03);
      rdc(CSW_ADDR_STAT, 8'hfc);
      wrr(CSW_ADDR_STAT, 8'h00);
      rdc(CSW_ADDR_STAT, 8'hfc);
      wrr(CSW_ADDR_MREQ, 8'h00);
      repeat (10) @(posedge clk_sys_in);
      rdc(CSW_ADDR_STAT, 8'h40);
      @(posedge clk_sys_in);
      preq.lfi <= 1'b1;
      repeat (10) @(posedge clk_sys_in);
      rdc(CSW_ADDR_STAT, 8'h50);
      @(posedge clk_sys_in);
      preq.lfi <= 1'b0;
      $display("test force done");
   endtask
   task automatic t_switch;
      wrr(CSW_ADDR_REQ, 8'h70);
      wait_sel(8'h70);
      rdc(CSW_ADDR_CUR, 8'h70);
      rdc(CSW_ADDR_CTL3, 8'h10);
      wrr(CSW_ADDR_REQ, 8'h10);
      wait_sel(8'h10);
      rdc(CSW_ADDR_STAT, 8'h41);
      $display("test switch done");
   endtask
   task automatic t_hold;
      wrr(CSW_ADDR_CTL3, 8'h80);
      wrr(CSW_ADDR_REQ, 8'h60);
      for (int i = 0; i < 100 && hold_ev !== 1'b1; i++) begin
         @(posedge clk_sys_in);
         #1;
      end
      chk({7'h0, hold_ev}, 8'h01);
      repeat (5) @(posedge clk_sys_in);
      #1 chk({1'b0, sel}, 8'h10);
      rdc(CSW_ADDR_CTL3, 8'h88);
      wrr(CSW_ADDR_CTL3, 8'h00);
      wait_sel(8'h60);
      rdc(CSW_ADDR_CTL3, 8'h10);
      $display("test hold done");
   endtask
   task automatic t_misc;
      wrr(CSW_ADDR_REQ, 8'h0a);
      rdc(CSW_ADDR_REQ, 8'h60);
      wrr(CSW_ADDR_REQ, 8'h3a);
      rdc(CSW_ADDR_REQ, 8'h60);
      wrr(CSW_ADDR_CUR, 8'h70);
      rdc(CSW_ADDR_CUR, 8'h60);
      wrr(CSW_ADDR_CTL3, 8'h40);
      repeat (3) @(posedge clk_sys_in);
      #1 chk({7'h0, spwr}, 8'h01);
      rdc(CSW_ADDR_CTL3, 8'h50);
      @(posedge clk_sys_in);
      xmode <= 3'h5;
      fsel <= 3'h3;
      repeat (3) @(posedge clk_sys_in);
      #1 chk({5'h0, xmode_o}, 8'h05);
      chk({5'h0, fsel_o}, 8'h03);
      $display("test misc done");
   endtask
   // ----
   // verdict and run
   // ----
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      fail_count++;
      print_verdict();
   end
   initial begin
      repeat (16) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      t_reset();
      t_force();
      t_switch();
      t_hold();
      t_misc();
      print_verdict();
   end
endmodule
